// *** verilog/sww_top.sv ***
// Sleep entry, wake decision and watchdog control for a small core.
// Assumes the core pulses the sleep and watchdog-clear inputs for one
// cycle as the instructions execute, and that wake sources are levels.
// What this block does
// - Watchdog runs when soft enable is 1, or config enable is 1.
// - Software cannot stop a watchdog enabled by configuration.
// - Control register upper bits read zero; bit 0 read/write, resets 0.
// - Postscaler ratio comes only from the programmed configuration field.
// - Sleep clears watchdog, clears power-down, sets time-out, stops oscillator.
// - During sleep the I/O ports hold their previous drive state.
// - Master clear, watchdog time-out or enabled interrupt ends sleep.
// - Only clockless peripherals may wake the device from sleep.
// - Master clear during sleep resets; other wakes resume execution.
// - Power-down flag set at power-up; time-out flag cleared on time-out.
// - Sleep prefetches the instruction at program counter plus two.
// - A wake source needs its own enable; global enable is ignored.
// - Global enable off continues in line; on, vectors after next.
// - Interrupt pending before sleep makes sleep a no-operation.
// - Interrupt during or after sleep: complete sleep, then wake at once.
// - Crystal modes wait 1024 oscillator periods on wake; RC and EC skip.
// - Awake time-out resets; asleep time-out wakes; clear resets watchdog.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module sww_top #(
    parameter int          PW           = 16,
    parameter int          WDT_BASE     = sww_pkg::WDT_BASE_CYCLES,
    parameter int          OST_LEN      = sww_pkg::OST_CYCLES,
    parameter logic [7:0]  CFG_WORD     = 8'h00
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_sys_rst,
    input  wire logic [sww_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [7:0]                 i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [7:0]                 o_rdata,
    input  wire logic                       i_sleep_exec,
    input  wire logic                       i_watchdog_clear_instruction,
    input  wire logic                       i_master_clear_pin,
    input  wire logic [15:0]                i_pc,
    input  wire logic                       i_global_interrupt_enable,
    input  wire logic                       i_int_pin_flag,
    input  wire logic                       i_int_pin_en,
    input  wire logic                       i_portb_change_flag,
    input  wire logic                       i_portb_change_en,
    input  wire logic [10:0]                i_periph_flag,
    input  wire logic [10:0]                i_periph_en,
    input  wire logic [10:0]                i_periph_clockless,
    input  wire logic                       i_crystal_mode,
    input  wire logic [7:0]                 i_port_out,
    input  wire logic [7:0]                 i_port_oe_n,
    output logic      [7:0]                 o_port_out,
    output logic      [7:0]                 o_port_oe_n,
    output logic                            o_osc_driver_on,
    output logic                            o_core_clk_en,
    output logic                            o_device_reset,
    output logic      [15:0]                o_prefetch_addr,
    output logic                            o_vector_to_isr,
    output logic                            o_sleeping,
    output logic                            o_watchdog_running
);
    sww_pkg::sww_state_t state;
    logic        soft_watchdog_enable;
    logic        powerdown_flag_n;
    logic        timeout_flag_n;
    logic [7:0]  watchdog_config_high;
    logic [7:0]  port_hold;
    logic [7:0]  oe_hold;
    logic        cfg_watchdog_enable;
    logic [2:0]  postscale_sel;
    logic [7:0]  post_count;
    logic [7:0]  post_limit;
    logic        base_tick;
    logic        wdt_timeout;
    logic        wdt_clear;
    logic        irq_pending;
    logic        sleep_taken;
    logic        wake_int;
    logic        wake_wdt;
    logic        ost_done;
    logic        ost_run;
    logic        ost_clear;

    // The configuration word is fixed at programming time, so it is latched
    // on every clock after reset and never written by software.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            watchdog_config_high <= 8'h00;
        end else begin
            watchdog_config_high <= CFG_WORD;
        end
    end

    assign cfg_watchdog_enable = watchdog_config_high[sww_pkg::CFG_EN_BIT];
    assign postscale_sel =
        watchdog_config_high[sww_pkg::CFG_PS_HI:sww_pkg::CFG_PS_LO];
    assign o_watchdog_running =
        cfg_watchdog_enable | soft_watchdog_enable;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            soft_watchdog_enable <= sww_pkg::WDT_CTRL_RESET[0];
        end else if (i_wr && i_addr == sww_pkg::ADDR_WDOG_CTRL) begin
            soft_watchdog_enable <= i_wdata[sww_pkg::SOFT_EN_BIT];
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                sww_pkg::ADDR_WDOG_CTRL:
                    o_rdata <= {7'h00, soft_watchdog_enable};
                sww_pkg::ADDR_WDOG_CFG:
                    o_rdata <= watchdog_config_high;
                sww_pkg::ADDR_RESET_CAUSE:
                    o_rdata <= {3'h0, timeout_flag_n, powerdown_flag_n, 3'h0};
                sww_pkg::ADDR_SLEEP_STATUS:
                    o_rdata <= {6'h00, o_watchdog_running, o_sleeping};
                default:
                    o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Enabled interrupt requests; the global enable plays no part here.
    assign irq_pending = (i_int_pin_flag & i_int_pin_en)
        | (i_portb_change_flag & i_portb_change_en)
        | (|(i_periph_flag & i_periph_en & i_periph_clockless));

    // A request seen in the sleep cycle itself turns sleep into a no-op.
    assign sleep_taken = i_sleep_exec && state == sww_pkg::SWW_RUN
        && !irq_pending;
    assign wdt_clear = sleep_taken || i_watchdog_clear_instruction;

    // The base watchdog period is counted on the core clock; a real part uses
    // its own RC oscillator, which this model folds into the same clock.
    sww_counter #(
        .W (16)
    ) u_wdt_base (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_clear   (wdt_clear || base_tick),
        .i_run     (o_watchdog_running),
        .i_limit   (16'(WDT_BASE - 1)),
        .o_done    (base_tick)
    );

    assign post_limit = 8'((8'h01 << postscale_sel) - 8'h01);

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            post_count <= 8'h00;
        end else if (wdt_clear || wdt_timeout) begin
            post_count <= 8'h00;
        end else if (base_tick) begin
            post_count <= post_count + 8'h01;
        end
    end

    assign wdt_timeout = base_tick && post_count == post_limit
        && o_watchdog_running;

    assign wake_int = state == sww_pkg::SWW_SLEEP && irq_pending;
    assign wake_wdt = state == sww_pkg::SWW_SLEEP && wdt_timeout;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= sww_pkg::SWW_RUN;
        end else if (i_master_clear_pin) begin
            state <= sww_pkg::SWW_RUN;
        end else begin
            case (state)
                sww_pkg::SWW_RUN: begin
                    if (sleep_taken) begin
                        state <= sww_pkg::SWW_SLEEP;
                    end
                end
                sww_pkg::SWW_SLEEP: begin
                    if (wake_int || wake_wdt) begin
                        state <= i_crystal_mode ? sww_pkg::SWW_OST
                                                : sww_pkg::SWW_RUN;
                    end
                end
                sww_pkg::SWW_OST: begin
                    if (ost_done) begin
                        state <= sww_pkg::SWW_RUN;
                    end
                end
                default: state <= sww_pkg::SWW_RUN;
            endcase
        end
    end

    assign ost_run   = state == sww_pkg::SWW_OST;
    assign ost_clear = state != sww_pkg::SWW_OST;

    sww_counter #(
        .W (11)
    ) u_ost (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_clear   (ost_clear),
        .i_run     (ost_run),
        .i_limit   (11'(OST_LEN - 1)),
        .o_done    (ost_done)
    );

    // Power-down flag reads 1 after power-up; time-out flag likewise.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            powerdown_flag_n <= 1'b1;
        end else if (sleep_taken) begin
            powerdown_flag_n <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            timeout_flag_n <= 1'b1;
        end else if (wdt_timeout) begin
            timeout_flag_n <= 1'b0;
        end else if (sleep_taken) begin
            timeout_flag_n <= 1'b1;
        end
    end

    // A time-out while awake is a device reset; asleep it is only a wake.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_device_reset <= 1'b0;
        end else begin
            o_device_reset <= i_master_clear_pin
                || (wdt_timeout && state == sww_pkg::SWW_RUN);
        end
    end

    // Port state is captured on sleep entry so the pins cannot drift.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            port_hold <= 8'h00;
            oe_hold   <= 8'hff;
        end else if (state == sww_pkg::SWW_RUN) begin
            port_hold <= i_port_out;
            oe_hold   <= i_port_oe_n;
        end
    end

    assign o_port_out  = port_hold;
    assign o_port_oe_n = oe_hold;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_prefetch_addr <= 16'h0000;
        end else if (i_sleep_exec) begin
            o_prefetch_addr <= i_pc + sww_pkg::PC_STEP;
        end
    end

    // The vector request is held until the core leaves sleep and returns.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_vector_to_isr <= 1'b0;
        end else if (i_master_clear_pin) begin
            o_vector_to_isr <= 1'b0;
        end else if (wake_int) begin
            o_vector_to_isr <= i_global_interrupt_enable;
        end else if (state == sww_pkg::SWW_RUN) begin
            o_vector_to_isr <= 1'b0;
        end
    end

    assign o_sleeping      = state != sww_pkg::SWW_RUN;
    assign o_osc_driver_on = state != sww_pkg::SWW_SLEEP;
    assign o_core_clk_en   = state == sww_pkg::SWW_RUN;
endmodule

// *** verilog/sww_pkg.sv ***
// Constants shared by the sleep, wake and watchdog control block.
// Assumes a single 20 MHz core clock and a plain register port.
package sww_pkg;
    localparam int          ADDR_W            = 4;
    localparam logic [3:0]  ADDR_WDOG_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_WDOG_CFG     = 4'h1;
    localparam logic [3:0]  ADDR_RESET_CAUSE  = 4'h2;
    localparam logic [3:0]  ADDR_SLEEP_STATUS = 4'h3;
    localparam int          SOFT_EN_BIT       = 0;
    localparam int          CFG_EN_BIT        = 0;
    localparam int          CFG_PS_LO         = 1;
    localparam int          CFG_PS_HI         = 3;
    localparam int          PD_BIT            = 3;
    localparam int          TO_BIT            = 4;
    localparam int          CLK_HZ            = 20000000;
    localparam int          OST_TOSC          = 1024;
    localparam int          OST_CYCLES        = OST_TOSC;
    localparam int          WDT_BASE_CYCLES   = 4096;
    localparam logic [7:0]  WDT_CTRL_RESET    = 8'h00;
    localparam int          NUM_WAKE_SRC      = 11;
    localparam logic [15:0] PC_STEP           = 16'h0002;
    typedef enum logic [1:0] {
        SWW_RUN,
        SWW_SLEEP,
        SWW_OST
    } sww_state_t;
endpackage

// *** verilog/sww_counter.sv ***
// Reusable up counter with synchronous clear and terminal flag.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module sww_counter #(
    parameter int W = 16
) (
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_clear,
    input  wire logic         i_run,
    input  wire logic [W-1:0] i_limit,
    output logic              o_done
);
    logic [W-1:0] count;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count <= '0;
        end else if (i_clear) begin
            count <= '0;
        end else if (i_run && count != i_limit) begin
            count <= count + 1'b1;
        end
    end

    assign o_done = i_run && (count == i_limit);
endmodule

// *** tb/sww_core_model.sv ***
// Core model: supplies the port drive state and the program counter.
// Assumes the bench resets it together with the block under test.
`timescale 1ns/1ps
module sww_core_model (
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    output logic      [7:0]  o_port_out,
    output logic      [7:0]  o_port_oe_n,
    output logic      [15:0] o_pc
);
    // The pattern moves every cycle, so a frozen port cannot pass by luck.
    logic [7:0] step = 8'h00;
    always_ff @(posedge i_mclk) begin
        step <= i_sys_rst ? 8'h00 : step + 8'h01;
    end
    assign o_port_out  = step;
    assign o_port_oe_n = step ^ 8'h5a;
    assign o_pc        = {step, 8'h10};
endmodule

// *** tb/sww_chk.sv ***
// Checker for the sleep, wake and watchdog block, bound to its top.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/1ps
module sww_chk #(
    parameter int         OST_LEN  = 4,
    parameter logic [7:0] CFG_WORD = 8'h00
) (
    input wire logic                       i_mclk,
    input wire logic                       i_sys_rst,
    input wire logic [sww_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0]                 i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_rd,
    input wire logic [7:0]                 o_rdata,
    input wire logic                       i_sleep_exec,
    input wire logic                       i_master_clear_pin,
    input wire logic [15:0]                i_pc,
    input wire logic                       i_global_interrupt_enable,
    input wire logic                       i_int_pin_flag,
    input wire logic                       i_int_pin_en,
    input wire logic                       i_portb_change_flag,
    input wire logic                       i_portb_change_en,
    input wire logic [10:0]                i_periph_flag,
    input wire logic [10:0]                i_periph_en,
    input wire logic [10:0]                i_periph_clockless,
    input wire logic                       i_crystal_mode,
    input wire logic [7:0]                 o_port_out,
    input wire logic [7:0]                 o_port_oe_n,
    input wire logic                       o_osc_driver_on,
    input wire logic                       o_core_clk_en,
    input wire logic                       o_device_reset,
    input wire logic [15:0]                o_prefetch_addr,
    input wire logic                       o_vector_to_isr,
    input wire logic                       o_sleeping,
    input wire logic                       o_watchdog_running
);
    logic req;
    logic ost;
    int   ost_cnt;
    // Clocked peripherals are left out: they cannot run while asleep.
    assign req = (i_int_pin_flag & i_int_pin_en)
               | (i_portb_change_flag & i_portb_change_en)
               | (|(i_periph_flag & i_periph_en & i_periph_clockless));
    assign ost = o_sleeping && o_osc_driver_on;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst)
            ost_cnt <= 0;
        else
            ost_cnt <= ost ? ost_cnt + 1 : 0;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_ctrl_upper_zero: assert property (i_rd && i_addr ==
        sww_pkg::ADDR_WDOG_CTRL |=> o_rdata[7:1] == 7'h00)
        else $error("control register upper bits not zero");
    a_wdog_enable: assert property (i_wr && i_addr ==
        sww_pkg::ADDR_WDOG_CTRL |=> o_watchdog_running ==
        ($past(i_wdata[0]) | CFG_WORD[0])) else $error("watchdog enable wrong");
    a_sleep_entry: assert property (i_sleep_exec && o_core_clk_en
        && !req && !i_master_clear_pin |=> o_sleeping && !o_osc_driver_on
        && o_prefetch_addr == $past(i_pc) + sww_pkg::PC_STEP)
        else $error("sleep entry wrong");
    a_sleep_noop: assert property (i_sleep_exec && o_core_clk_en && req
        |=> !o_sleeping) else $error("sleep with pending request entered");
    a_port_hold: assert property (o_sleeping && $past(o_sleeping)
        |-> $stable(o_port_out) && $stable(o_port_oe_n))
        else $error("port state moved while asleep");
    a_clk_gate: assert property (!o_osc_driver_on
        |-> o_sleeping && !o_core_clk_en) else $error("clock gating wrong");
    a_master_clear_pin_reset: assert property (i_master_clear_pin
        |=> o_device_reset && !o_sleeping) else $error("master clear missed");
    a_wake_int: assert property (!o_osc_driver_on && req
        && !i_master_clear_pin |=> o_osc_driver_on
        && o_sleeping == $past(i_crystal_mode)
        && o_vector_to_isr == $past(i_global_interrupt_enable))
        else $error("interrupt wake wrong");
    a_no_spurious: assert property (!o_osc_driver_on && !req
        && !i_master_clear_pin && !o_watchdog_running |=> !o_osc_driver_on)
        else $error("woke without a wake event");
    a_ost_len: assert property ($fell(ost) |-> ost_cnt == OST_LEN)
        else $error("start-up wait length wrong");
    c_sleep: cover property (i_sleep_exec && o_core_clk_en && !req);
    c_ost_exit: cover property ($fell(ost));
    c_vector: cover property (o_vector_to_isr);
endmodule
bind sww_top sww_chk #(.OST_LEN(OST_LEN), .CFG_WORD(CFG_WORD)) u_chk (.*);

// *** tb/sww_top_tb_top.sv ***
// Self-checking bench for the sleep, wake and watchdog block.
// Assumes the core model supplies port state and program counter.
`timescale 1ns/1ps
module sww_top_tb_top;
    localparam logic [7:0] CFG = 8'h04;
    logic [sww_pkg::ADDR_W-1:0] i_addr = 4'h0;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic i_sleep_exec = 1'b0, i_watchdog_clear_instruction = 1'b0;
    logic i_master_clear_pin = 1'b0, i_global_interrupt_enable = 1'b0;
    logic i_int_pin_flag = 1'b0, i_int_pin_en = 1'b0, i_crystal_mode = 1'b0;
    logic i_portb_change_flag = 1'b0, i_portb_change_en = 1'b0;
    logic [10:0] i_periph_flag = 11'h000, i_periph_en = 11'h000;
    logic [10:0] i_periph_clockless = 11'h7fe;
    logic [7:0]  i_wdata = 8'h00, i_port_out, i_port_oe_n, rd_val;
    logic [7:0]  o_rdata, o_port_out, o_port_oe_n;
    logic [15:0] i_pc, o_prefetch_addr;
    logic o_osc_driver_on, o_core_clk_en, o_device_reset, o_vector_to_isr;
    logic o_sleeping, o_watchdog_running;
    int   errors = 0, cmp_count = 0, rst_seen = 0;
    sww_core_model core (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .o_port_out(i_port_out), .o_port_oe_n(i_port_oe_n), .o_pc(i_pc));
    // Short counts keep the run brief; expectations follow these values.
    sww_top #(.WDT_BASE(8), .OST_LEN(4), .CFG_WORD(CFG)) uut (.*);
    always #25 i_mclk = ~i_mclk;
    always @(negedge i_mclk) if (o_device_reset === 1'b1) rst_seen++;
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        tick();
        i_wr <= 1'b0;
        tick();
    endtask
    task automatic rd(input logic [3:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        tick();
        i_rd <= 1'b0;
        rd_val = o_rdata;
        tick();
    endtask
    task automatic do_sleep();
        i_sleep_exec <= 1'b1;
        tick();
        i_sleep_exec <= 1'b0;
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // A wake that never comes ends the run instead of hanging it.
    task automatic wait_run(input int lim);
        int k;
        for (k = 0; k < lim && o_core_clk_en !== 1'b1; k++) tick();
        if (o_core_clk_en !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task automatic t_regs();
        rd(sww_pkg::ADDR_WDOG_CTRL);
        chk(rd_val, 8'h00);
        rd(sww_pkg::ADDR_RESET_CAUSE);
        chk(rd_val & 8'h18, 8'h18);
        wr(sww_pkg::ADDR_WDOG_CTRL, 8'hff);
        rd(sww_pkg::ADDR_WDOG_CTRL);
        chk(rd_val, 8'h01);
        chk(o_watchdog_running, 1'b1);
        rd(sww_pkg::ADDR_SLEEP_STATUS);
        chk(rd_val, 8'h02);
        wr(sww_pkg::ADDR_WDOG_CTRL, 8'h00);
        wr(sww_pkg::ADDR_WDOG_CFG, 8'hff);
        rd(sww_pkg::ADDR_WDOG_CFG);
        chk(rd_val, CFG);
        chk(o_watchdog_running, 1'b0);
        rd(4'hf);
        chk(rd_val, 8'h00);
    endtask
    task automatic t_noop();
        i_portb_change_flag <= 1'b1;
        i_portb_change_en <= 1'b1;
        tick();
        do_sleep();
        chk(o_sleeping, 1'b0);
        i_portb_change_flag <= 1'b0;
        rd(sww_pkg::ADDR_RESET_CAUSE);
        chk(rd_val & 8'h18, 8'h18);
    endtask
    task automatic t_int(input logic global_interrupt_enable, input logic xtal);
        i_global_interrupt_enable <= global_interrupt_enable;
        i_crystal_mode <= xtal;
        i_int_pin_flag <= 1'b1;
        i_periph_flag <= 11'h001;
        i_periph_en <= 11'h003;
        tick();
        do_sleep();
        chk(o_osc_driver_on, 1'b0);
        tick(3);
        chk(o_sleeping, 1'b1);
        i_periph_flag <= 11'h003;
        tick();
        chk(o_osc_driver_on, 1'b1);
        chk(o_vector_to_isr, global_interrupt_enable);
        chk(o_core_clk_en, !xtal);
        wait_run(20);
        i_periph_flag <= 11'h000;
        i_int_pin_flag <= 1'b0;
        rd(sww_pkg::ADDR_RESET_CAUSE);
        chk(rd_val & 8'h18, 8'h10);
    endtask
    task automatic t_wdt();
        wr(sww_pkg::ADDR_WDOG_CTRL, 8'h01);
        do_sleep();
        wait_run(200);
        rd(sww_pkg::ADDR_RESET_CAUSE);
        chk(rd_val & 8'h18, 8'h00);
        rst_seen = 0;
        repeat (8) begin
            i_watchdog_clear_instruction <= 1'b1;
            tick();
            i_watchdog_clear_instruction <= 1'b0;
            tick(9);
        end
        chk(rst_seen, 0);
        tick(40);
        chk(rst_seen > 0, 1'b1);
        wr(sww_pkg::ADDR_WDOG_CTRL, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        tick(2);
        t_regs();
        t_noop();
        t_int(1'b1, 1'b1);
        t_int(1'b0, 1'b0);
        t_wdt();
        do_sleep();
        tick(2);
        rst_seen = 0;
        i_master_clear_pin <= 1'b1;
        tick();
        i_master_clear_pin <= 1'b0;
        tick();
        chk(rst_seen > 0, 1'b1);
        chk(o_sleeping, 1'b0);
        tally_and_finish();
    end
endmodule
